// [act_pkg.sv]
// shared constants, types and timing tables of the conversion sequencer
`default_nettype none
package act_pkg;
  localparam int unsigned ACT_SW = 4;
  localparam int unsigned ACT_DW = 16;

  // register byte offsets, then the config and result page numbers (paddr[11:6])
  localparam logic [11:0] ACT_CONVERTER_CONTROL_ONE    = 12'h000;
  localparam logic [11:0] ACT_CONVERTER_CONTROL_TWO    = 12'h004;
  localparam logic [11:0] ACT_INTERRUPT_CYCLE_REGISTER = 12'h008;
  localparam logic [11:0] ACT_INTERRUPT_SOURCE_SELECT  = 12'h00C;
  localparam logic [11:0] ACT_FORCE                    = 12'h010;
  localparam logic [11:0] ACT_STATUS                   = 12'h014;
  localparam logic [11:0] ACT_MASK                     = 12'h018;
  localparam logic [11:0] ACT_SEQ_STATE                = 12'h01C;
  localparam logic [11:0] ACT_TEMP_SENSOR_CONTROL      = 12'h020;
  localparam logic [5:0]  ACT_SLOT_CFG_PAGE            = 6'h04;
  localparam logic [5:0]  ACT_RESULT_PAGE              = 6'h08;

  // slot config word layout
  localparam int unsigned ACT_CFG_TSEL_LSB = 16;

  // status and mask bit positions
  localparam int unsigned ACT_ST_INT = 0;
  localparam int unsigned ACT_ST_DMA = 1;

  // reset values
  localparam logic [7:0] ACT_OFFSET_RST = 8'h01;
  localparam logic [8:0] ACT_WIN_RST    = 9'h000;

  typedef logic [ACT_SW-1:0] act_slot_t;

  typedef struct packed {
    logic res16;
    logic dma_timing_enable;
    logic interrupt_pulse_position;
  } act_ctl1_s;

  typedef struct packed {
    act_slot_t         slot;
    logic [ACT_DW-1:0] data;
  } act_conv_s;

  typedef struct packed {
    logic [8:0] t_go;
    logic [8:0] t_eoc;
    logic [8:0] t_lat;
    logic [8:0] t_off;
  } act_tim_s;

  typedef enum logic [1:0] {ACT_IDLE, ACT_SAMPLE, ACT_HOLD} act_seq_e;

  // cycles from the last sample-window cycle, indexed by prescale code
  localparam logic [8:0] ACT_EOC12 [16] = '{9'h00B, 9'h00B, 9'h015,
    9'h01A, 9'h01F, 9'h024, 9'h029, 9'h02E, 9'h033, 9'h038, 9'h03D,
    9'h042, 9'h047, 9'h04C, 9'h051, 9'h056};
  localparam logic [8:0] ACT_LAT12 [16] = '{9'h00D, 9'h00D, 9'h017,
    9'h01C, 9'h022, 9'h027, 9'h02C, 9'h031, 9'h037, 9'h03C, 9'h041,
    9'h046, 9'h04C, 9'h051, 9'h056, 9'h05B};
  localparam logic [8:0] ACT_EOC16 [16] = '{9'h01F, 9'h01F, 9'h03C,
    9'h04B, 9'h05A, 9'h068, 9'h077, 9'h086, 9'h095, 9'h0A3, 9'h0B2,
    9'h0C1, 9'h0D0, 9'h0DE, 9'h0ED, 9'h0FC};
  localparam logic [8:0] ACT_LAT16 [16] = '{9'h020, 9'h020, 9'h03D,
    9'h04B, 9'h05B, 9'h06A, 9'h078, 9'h086, 9'h096, 9'h0A5, 9'h0B3,
    9'h0C1, 9'h0D1, 9'h0E0, 9'h0EE, 9'h0FC};
endpackage
`default_nettype wire

// [act_conv_tmr.sv]
// one in-flight conversion: counts cycles from the last window cycle
`default_nettype none
module act_conv_tmr (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               start,
  input  wire act_pkg::act_conv_s conv_in,
  input  wire act_pkg::act_tim_s  tim_in,
  output logic                    busy,
  output logic                    go_evt,
  output logic                    eoc_evt,
  output logic                    lat_evt,
  output logic                    off_evt,
  output var act_pkg::act_conv_s  conv_out
);
  act_pkg::act_tim_s  tim_ff;
  act_pkg::act_tim_s  tim;
  act_pkg::act_conv_s conv_ff;
  act_pkg::act_conv_s nxt_conv;
  logic [8:0]         cnt_ff;
  logic [8:0]         nxt_cnt;
  logic [8:0]         c;
  logic               busy_ff;
  logic               nxt_busy;
  logic               act;

  // the start cycle is count zero, so the eoc and latch events land exactly
  // their table figure of cycles after the final window cycle
  always_comb begin
    act      = start | busy_ff;
    tim      = start ? tim_in : tim_ff;
    c        = start ? 9'h000 : cnt_ff;
    go_evt   = act && (c == tim.t_go);
    eoc_evt  = act && (c == tim.t_eoc);
    lat_evt  = act && (c == tim.t_lat);
    off_evt  = act && (c == tim.t_off);
    nxt_busy = act && (c != tim.t_lat);
    nxt_cnt  = act ? c + 9'h001 : cnt_ff;
    nxt_conv = start ? conv_in : conv_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim_ff  <= '0;
      conv_ff <= '0;
      cnt_ff  <= 9'h000;
      busy_ff <= 1'b0;
    end else if (ce) begin
      tim_ff  <= tim;
      conv_ff <= nxt_conv;
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy     = busy_ff;
  assign conv_out = conv_ff;
endmodule
`default_nettype wire

// [act_res_mem.sv]
// per-slot result storage with a registered read port
`default_nettype none
module act_res_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4,
  parameter int unsigned DW    = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_ff [DEPTH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      rdata <= '0;
    end else if (ce) begin
      if (we) begin
        mem_ff[waddr] <= wdata;
      end
      rdata <= mem_ff[raddr];
    end
  end
endmodule
`default_nettype wire

// [act_ctrl.sv]
// conversion sequencer: apb registers, slot scheduling, timing events
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module act_ctrl #(
  parameter int unsigned NSLOT = 16,
  parameter int unsigned NTRIG = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [NTRIG-1:0] trig,
  input  wire logic [15:0] adc_data,
  output logic             sh_open,
  output logic      [3:0]  sh_slot,
  output logic             converter_clock_en,
  output logic             temp_sensor_enable,
  output logic             conv_int,
  output logic             dma_trig,
  output logic             irq
);
  if (NSLOT < 2 || NSLOT > 16 || NTRIG < 1 || NTRIG > 4) begin : g_chk
    $error("act_ctrl: NSLOT must be 2..16 and NTRIG 1..4");
  end

  // register state
  act_pkg::act_ctl1_s ctl1_ff, nxt_ctl1;
  logic [3:0]         presc_ff, nxt_presc;
  logic [7:0]         off_ff, nxt_off;
  act_pkg::act_slot_t intsel_ff, nxt_intsel;
  logic [1:0]         mask_ff, nxt_mask;
  logic               tsens_ff, nxt_tsens;
  logic [8:0]         win_ff [NSLOT];
  logic [8:0]         nxt_win [NSLOT];
  logic [1:0]         tsel_ff [NSLOT];
  logic [1:0]         nxt_tsel [NSLOT];
  logic [31:0]        prd_ff, nxt_prd;
  logic               err_ff, nxt_err;
  logic               res_rd_ff, nxt_res_rd;
  logic               st_rd_ff, nxt_st_rd;
  logic [1:0]         stat_ff, nxt_stat;
  logic               setup, wr, rd, cfg_hit, res_hit;
  act_pkg::act_slot_t aidx;
  logic [15:0]        mem_rdata;

  // sequencer state
  act_pkg::act_seq_e  state_ff, nxt_state;
  logic [8:0]         wcnt_ff, nxt_wcnt;
  act_pkg::act_slot_t slot_ff, nxt_slot;
  act_pkg::act_slot_t rr_ff, nxt_rr;
  act_pkg::act_slot_t pick;
  logic [NSLOT-1:0]   pend_ff, nxt_pend, pend_set;
  logic               cur_ff, nxt_cur;
  logic               found, start, go_now;
  logic [4:0]         acc_ff, nxt_acc, ratio_h, acc_sum;

  // conversion timers, used in turn so 12-bit results may overlap
  act_pkg::act_tim_s  tim;
  act_pkg::act_conv_s t_conv [2];
  logic [1:0]         t_start, t_busy, t_go, t_eoc, t_lat, t_off;
  logic [1:0]         t_match, t_int, t_dma;

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite && ce;
  assign rd      = psel && penable && !pwrite && ce;
  assign aidx    = paddr[5:2];
  assign cfg_hit = paddr[11:6] == act_pkg::ACT_SLOT_CFG_PAGE &&
                   paddr[1:0] == 2'h0 && int'(aidx) < NSLOT;
  assign res_hit = paddr[11:6] == act_pkg::ACT_RESULT_PAGE &&
                   paddr[1:0] == 2'h0 && int'(aidx) < NSLOT;

  always_comb begin
    nxt_ctl1   = ctl1_ff;
    nxt_presc  = presc_ff;
    nxt_off    = off_ff;
    nxt_intsel = intsel_ff;
    nxt_mask   = mask_ff;
    nxt_tsens  = tsens_ff;
    nxt_win    = win_ff;
    nxt_tsel   = tsel_ff;
    nxt_prd    = prd_ff;
    nxt_err    = err_ff;
    nxt_res_rd = res_rd_ff;
    nxt_st_rd  = st_rd_ff;
    // read data and error are fixed in the setup cycle
    if (setup) begin
      nxt_prd    = 32'h0000_0000;
      nxt_err    = 1'b0;
      nxt_res_rd = res_hit;
      nxt_st_rd  = paddr == act_pkg::ACT_STATUS;
      if (paddr == act_pkg::ACT_CONVERTER_CONTROL_ONE) begin
        nxt_prd = 32'(ctl1_ff);
      end else if (paddr == act_pkg::ACT_CONVERTER_CONTROL_TWO) begin
        nxt_prd = 32'(presc_ff);
      end else if (paddr == act_pkg::ACT_INTERRUPT_CYCLE_REGISTER) begin
        nxt_prd = 32'(off_ff);
      end else if (paddr == act_pkg::ACT_INTERRUPT_SOURCE_SELECT) begin
        nxt_prd = 32'(intsel_ff);
      end else if (paddr == act_pkg::ACT_STATUS) begin
        nxt_prd = 32'(stat_ff);
      end else if (paddr == act_pkg::ACT_MASK) begin
        nxt_prd = 32'(mask_ff);
      end else if (paddr == act_pkg::ACT_SEQ_STATE) begin
        nxt_prd = {8'h00, 8'(pend_ff), 6'h00, state_ff, rr_ff, slot_ff};
      end else if (paddr == act_pkg::ACT_TEMP_SENSOR_CONTROL) begin
        nxt_prd = 32'(tsens_ff);
      end else if (cfg_hit) begin
        nxt_prd = 32'(win_ff[aidx]);
        nxt_prd[act_pkg::ACT_CFG_TSEL_LSB +: 2] = tsel_ff[aidx];
      end else if (!res_hit && paddr != act_pkg::ACT_FORCE) begin
        nxt_err = 1'b1;
      end
    end
    if (wr && !err_ff) begin
      if (paddr == act_pkg::ACT_CONVERTER_CONTROL_ONE) begin
        nxt_ctl1 = act_pkg::act_ctl1_s'(pwdata[2:0]);
      end else if (paddr == act_pkg::ACT_CONVERTER_CONTROL_TWO) begin
        nxt_presc = pwdata[3:0];
      end else if (paddr == act_pkg::ACT_INTERRUPT_CYCLE_REGISTER) begin
        nxt_off = pwdata[7:0];
      end else if (paddr == act_pkg::ACT_INTERRUPT_SOURCE_SELECT) begin
        nxt_intsel = pwdata[3:0];
      end else if (paddr == act_pkg::ACT_MASK) begin
        nxt_mask = pwdata[1:0];
      end else if (paddr == act_pkg::ACT_TEMP_SENSOR_CONTROL) begin
        nxt_tsens = pwdata[0];
      end else if (cfg_hit) begin
        nxt_win[aidx]  = pwdata[8:0];
        nxt_tsel[aidx] = pwdata[act_pkg::ACT_CFG_TSEL_LSB +: 2];
      end
    end
    // set wins over the read-clear; only bits already returned clear
    nxt_stat = stat_ff;
    if (rd && st_rd_ff) begin
      nxt_stat = stat_ff & ~prd_ff[1:0];
    end
    nxt_stat[act_pkg::ACT_ST_INT] = nxt_stat[act_pkg::ACT_ST_INT] | conv_int;
    nxt_stat[act_pkg::ACT_ST_DMA] = nxt_stat[act_pkg::ACT_ST_DMA] | dma_trig;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_ff   <= '0;
      presc_ff  <= 4'h0;
      off_ff    <= act_pkg::ACT_OFFSET_RST;
      intsel_ff <= '0;
      mask_ff   <= 2'h0;
      tsens_ff  <= 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
        win_ff[i]  <= act_pkg::ACT_WIN_RST;
        tsel_ff[i] <= 2'h0;
      end
      prd_ff    <= 32'h0000_0000;
      err_ff    <= 1'b0;
      res_rd_ff <= 1'b0;
      st_rd_ff  <= 1'b0;
      stat_ff   <= 2'h0;
    end else if (ce) begin
      ctl1_ff   <= nxt_ctl1;
      presc_ff  <= nxt_presc;
      off_ff    <= nxt_off;
      intsel_ff <= nxt_intsel;
      mask_ff   <= nxt_mask;
      tsens_ff  <= nxt_tsens;
      win_ff    <= nxt_win;
      tsel_ff   <= nxt_tsel;
      prd_ff    <= nxt_prd;
      err_ff    <= nxt_err;
      res_rd_ff <= nxt_res_rd;
      st_rd_ff  <= nxt_st_rd;
      stat_ff   <= nxt_stat;
    end
  end

  // result words come straight from storage, which a latch updates
  // only at the latch event: an earlier read sees the old word
  act_res_mem #(
    .DEPTH (NSLOT),
    .AW    (act_pkg::ACT_SW),
    .DW    (act_pkg::ACT_DW)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .we      (|t_lat),
    .waddr   (t_lat[0] ? t_conv[0].slot : t_conv[1].slot),
    .wdata   (t_lat[0] ? t_conv[0].data : t_conv[1].data),
    .raddr   (aidx),
    .rdata   (mem_rdata)
  );

  assign prdata  = res_rd_ff ? {16'h0000, mem_rdata} : prd_ff;
  assign pready  = ce;
  assign pslverr = psel && penable && err_ff;

  // round-robin choice among pending slots
  always_comb begin
    int j;
    j     = 0;
    found = 1'b0;
    pick  = rr_ff;
    for (int k = 0; k < NSLOT; k++) begin
      j = (int'(rr_ff) + k) % NSLOT;
      if (!found && pend_ff[j]) begin
        found = 1'b1;
        pick  = act_pkg::act_slot_t'(j);
      end
    end
    for (int i = 0; i < NSLOT; i++) begin
      pend_set[i] = trig[tsel_ff[i]] ||
                    (wr && paddr == act_pkg::ACT_FORCE && pwdata[i]);
    end
  end

  // 16-bit waits for the latch, 12-bit only for the end of conversion
  always_comb begin
    tim.t_eoc = ctl1_ff.res16 ? act_pkg::ACT_EOC16[presc_ff]
                              : act_pkg::ACT_EOC12[presc_ff];
    tim.t_lat = ctl1_ff.res16 ? act_pkg::ACT_LAT16[presc_ff]
                              : act_pkg::ACT_LAT12[presc_ff];
    tim.t_go  = (ctl1_ff.res16 ? tim.t_lat : tim.t_eoc) - 9'h001;
    tim.t_off = {1'b0, off_ff};
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_wcnt  = wcnt_ff;
    nxt_slot  = slot_ff;
    nxt_rr    = rr_ff;
    nxt_cur   = cur_ff;
    nxt_pend  = pend_ff | pend_set;
    start     = 1'b0;
    go_now    = t_go[cur_ff];
    if (found && (state_ff == act_pkg::ACT_IDLE ||
                  (state_ff == act_pkg::ACT_HOLD && go_now))) begin
      nxt_state      = act_pkg::ACT_SAMPLE;
      nxt_slot       = pick;
      nxt_wcnt       = win_ff[pick];
      nxt_pend[pick] = pend_set[pick];
      nxt_rr         = act_pkg::act_slot_t'((int'(pick) + 1) % NSLOT);
    end else if (state_ff == act_pkg::ACT_HOLD && go_now) begin
      nxt_state = act_pkg::ACT_IDLE;
    end else if (state_ff == act_pkg::ACT_SAMPLE) begin
      if (wcnt_ff == 9'h000) begin
        start     = 1'b1;
        nxt_cur   = ~cur_ff;
        nxt_state = act_pkg::ACT_HOLD;
      end else begin
        nxt_wcnt = wcnt_ff - 9'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= act_pkg::ACT_IDLE;
      wcnt_ff  <= 9'h000;
      slot_ff  <= '0;
      rr_ff    <= '0;
      pend_ff  <= '0;
      cur_ff   <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
      wcnt_ff  <= nxt_wcnt;
      slot_ff  <= nxt_slot;
      rr_ff    <= nxt_rr;
      pend_ff  <= nxt_pend;
      cur_ff   <= nxt_cur;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_tmr
    assign t_start[g] = start && (cur_ff != 1'(g));
    act_conv_tmr u_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .start    (t_start[g]),
      .conv_in  ({slot_ff, adc_data}),
      .tim_in   (tim),
      .busy     (t_busy[g]),
      .go_evt   (t_go[g]),
      .eoc_evt  (t_eoc[g]),
      .lat_evt  (t_lat[g]),
      .off_evt  (t_off[g]),
      .conv_out (t_conv[g])
    );
    // in the start cycle the stored slot is still the previous one
    assign t_match[g] = t_start[g] ? slot_ff == intsel_ff
                                   : t_conv[g].slot == intsel_ff;
    assign t_int[g] = t_match[g] && (ctl1_ff.interrupt_pulse_position ?
                      t_eoc[g]
                      : t_off[g]);
    assign t_dma[g] = ctl1_ff.dma_timing_enable ?
                      t_match[g] && t_lat[g] : t_int[g];
  end

  // divider in half steps: code 0 and 1 give 1, code n gives 1 + n/2
  always_comb begin
    ratio_h = (presc_ff < 4'h2) ? 5'h02 : {1'b0, presc_ff} + 5'h02;
    acc_sum = acc_ff + 5'h02;
    converter_clock_en = acc_sum >= ratio_h;
    nxt_acc = converter_clock_en ? acc_sum - ratio_h : acc_sum;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 5'h00;
    end else if (ce) begin
      acc_ff <= nxt_acc;
    end
  end

  assign sh_open            = state_ff == act_pkg::ACT_SAMPLE;
  assign sh_slot            = slot_ff;
  assign temp_sensor_enable = tsens_ff;
  assign conv_int           = |t_int;
  assign dma_trig           = |t_dma;
  assign irq                = |(stat_ff & mask_ff);

  logic [8:0] open_len_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_len_ff <= 9'h000;
    end else if (ce) begin
      open_len_ff <= sh_open && !start ? open_len_ff + 9'h001 : 9'h000;
    end
  end

  property p_win;
    @(posedge pclk iff ce) disable iff (!presetn)
    start |-> open_len_ff == win_ff[slot_ff];
  endproperty
  a_win: assert property (p_win) else $error("window length wrong");

  property p_lat12;
    @(posedge pclk iff ce) disable iff (!presetn)
    t_start[0] && !ctl1_ff.res16 && presc_ff == 4'h0 |-> ##11 t_eoc[0]
      ##2 t_lat[0];
  endproperty
  a_lat12: assert property (p_lat12) else $error("12-bit timing wrong");

  property p_lat16;
    @(posedge pclk iff ce) disable iff (!presetn)
    start && ctl1_ff.res16 && presc_ff == 4'hF |-> ##252 (|t_lat);
  endproperty
  a_lat16: assert property (p_lat16) else $error("16-bit latch wrong");

  property p_wait16;
    @(posedge pclk iff ce) disable iff (!presetn)
    $rose(sh_open) && ctl1_ff.res16 |->
      !(t_busy[0] && !t_lat[0]) && !(t_busy[1] && !t_lat[1]);
  endproperty
  a_wait16: assert property (p_wait16) else $error("16-bit overlap");

  property p_early;
    @(posedge pclk iff ce) disable iff (!presetn)
    start && slot_ff == intsel_ff && off_ff == 8'h01 &&
      !ctl1_ff.interrupt_pulse_position |-> ##1 conv_int;
  endproperty
  a_early: assert property (p_early) else $error("early flag late");

  property p_late;
    @(posedge pclk iff ce) disable iff (!presetn)
    conv_int && ctl1_ff.interrupt_pulse_position |-> |t_eoc;
  endproperty
  a_late: assert property (p_late) else $error("late flag off eoc");

  property p_dma_on;
    @(posedge pclk iff ce) disable iff (!presetn)
    dma_trig && ctl1_ff.dma_timing_enable |-> u_mem.we;
  endproperty
  a_dma_on: assert property (p_dma_on) else $error("dma before latch");

  property p_dma_off;
    @(posedge pclk iff ce) disable iff (!presetn)
    !ctl1_ff.dma_timing_enable |-> dma_trig == conv_int;
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma not at flag");

  property p_rr;
    @(posedge pclk iff ce) disable iff (!presetn)
    state_ff != act_pkg::ACT_SAMPLE && nxt_state == act_pkg::ACT_SAMPLE |->
      pend_ff[nxt_slot];
  endproperty
  a_rr: assert property (p_rr) else $error("slot not pending");

  property p_div1;
    @(posedge pclk iff ce) disable iff (!presetn)
    presc_ff == 4'h0 && $past(presc_ff) == 4'h0 |-> converter_clock_en;
  endproperty
  a_div1: assert property (p_div1) else $error("ratio 1 clock gap");
endmodule
`default_nettype wire

// [act_dma_mdl.sv]
// dma and processor side observer: times events against the sample window
`default_nettype none
module act_dma_mdl (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sh_open,
  input  wire logic [3:0] sh_slot,
  input  wire logic       conv_int,
  input  wire logic       dma_trig,
  output logic      [8:0] wlen,
  output logic      [8:0] int_dly,
  output logic      [8:0] dma_dly,
  output logic      [8:0] gap,
  output logic      [7:0] n_int,
  output logic      [7:0] slots
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cyc_ff;
  logic [15:0] last_ff;
  logic [8:0]  run_ff;
  logic        was_ff;
  // every delay counts from the final window cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cyc_ff, last_ff, run_ff, was_ff} <= '0;
      {wlen, int_dly, dma_dly, gap, n_int, slots} <= '0;
    end else begin
      cyc_ff <= cyc_ff + 16'h1;
      was_ff <= sh_open;
      run_ff <= sh_open ? run_ff + 9'h1 : 9'h0;
      if (sh_open) begin
        last_ff <= cyc_ff;
        wlen    <= run_ff + 9'h1;
      end
      if (sh_open && !was_ff) begin
        gap   <= 9'(cyc_ff - last_ff);
        slots <= {slots[3:0], sh_slot};
      end
      if (conv_int) begin
        int_dly <= 9'(cyc_ff - last_ff);
        n_int   <= n_int + 8'h1;
      end
      // the dma side records the delay of every trigger it sees
      if (dma_trig) begin
        dma_dly <= 9'(cyc_ff - last_ff);
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// testbench for the conversion sequencer: timing, round robin, irq
`default_nettype none
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        sh_open, converter_clock_en, temp_sensor_enable, conv_int;
  logic        dma_trig, irq, err, irq_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  trig, sh_slot;
  logic [15:0] adc_data;
  logic [8:0]  wlen, int_dly, dma_dly, gap;
  logic [7:0]  n_int, slots, n0;
  int          failures, samples_checked, cyc;

  act_ctrl dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trig, .adc_data, .sh_open,
    .sh_slot, .converter_clock_en, .temp_sensor_enable, .conv_int,
    .dma_trig, .irq);
  act_dma_mdl mdl_u (.pclk, .presetn, .sh_open, .sh_slot, .conv_int,
    .dma_trig, .wlen, .int_dly, .dma_dly, .gap, .n_int, .slots);

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  // read data captured at the accepting edge, so tasks never race it
  always @(posedge pclk) begin
    irq_q <= irq;
    if (psel && penable && pready) begin
      rd  <= prdata;
      err <= pslverr;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // pulse a trigger, then wait bounded for the flag
  task automatic fire(input int i);
    trig <= 4'h1 << i;
    @(posedge pclk);
    trig <= 4'h0;
    n0 = n_int;
    for (int k = 0; k < 400 && n_int == n0; k++) @(posedge pclk);
    `CHK(n_int != n0, 1'h1)
  endtask

  task automatic t_regs();
    rdc(12'h008, 32'h1);
    rdc(12'h000, 32'h0);
    apb(1'h0, 12'h0FC, 32'h0);
    `CHK(err, 1'h1)
    wr(12'h020, 32'h1);
    `CHK(temp_sensor_enable, 1'h1)
    // sensor slot: 23-cycle window, 460 ns at 50 MHz
    wr(12'h108, 32'h16);
    rdc(12'h108, 32'h16);
    $display("register test done");
  endtask

  task automatic t_early();
    // slot 0 alone on trigger 3: every other slot resets onto trigger 0
    wr(12'h100, 32'h30003);
    adc_data <= 16'h1234;
    fire(3);
    repeat (16) @(posedge pclk);
    `CHK(wlen, 9'h004)
    `CHK(int_dly, 9'h001)
    `CHK(dma_dly, 9'h001)
    rdc(12'h200, 32'h1234);
    wr(12'h000, 32'h2);
    adc_data <= 16'h5678;
    fire(3);
    rdc(12'h200, 32'h1234);
    repeat (16) @(posedge pclk);
    `CHK(dma_dly, 9'h00D)
    rdc(12'h200, 32'h5678);
    $display("early mode test done");
  endtask

  task automatic t_late16();
    int n;
    wr(12'h000, 32'h5);
    wr(12'h004, 32'hF);
    // ratio 8.5 gives exactly two enables in any 17 cycles
    n = 0;
    repeat (17) begin
      @(posedge pclk);
      n += int'(converter_clock_en);
    end
    `CHK(n, 2)
    fire(3);
    repeat (4) @(posedge pclk);
    `CHK(int_dly, 9'h0FC)
    `CHK(dma_dly, 9'h0FC)
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    $display("late 16-bit test done");
  endtask

  task automatic t_rr();
    logic [7:0] b;
    wr(12'h100, 32'h20005);
    wr(12'h104, 32'h20000);
    b = n_int;
    fire(2);
    repeat (16) @(posedge pclk);
    `CHK(slots, 8'h10)
    `CHK(gap, 9'h00B)
    `CHK(wlen, 9'h006)
    `CHK(n_int, b + 8'h01)
    $display("round robin test done");
  endtask

  task automatic t_irq();
    `CHK(irq_q, 1'h0) // masked
    wr(12'h018, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq_q, 1'h1)
    apb(1'h0, 12'h014, 32'h0);
    `CHK(rd[0], 1'h1)
    apb(1'h0, 12'h014, 32'h0);
    `CHK(rd[0], 1'h0)
    repeat (2) @(posedge pclk);
    `CHK(irq_q, 1'h0)
    $display("interrupt test done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    ce = 1'h1;
    paddr = 12'h0;
    pwdata = 32'h0;
    trig = 4'h0;
    adc_data = 16'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_early();
    t_late16();
    t_rr();
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire
